/* File: drfs_sequencer.sv */
// Behaviour
// (R1) Low battery blinks indicator, 4 s, 25% lit
// (R2) Battery above threshold: indicator steadily on
// (R3) Zero current closes anti-ring switch until switching
// (R4) Enable rise starts linear current-limited boost phase
// (R5) Fixed duty to 1.6V, then PFM control
// (R6) Buck enabled only after boost reaches 92.5%
// (R7) Supply-ok rises 10-50 ms after buck ready
// (R8) Supply-ok needs both feedbacks and battery; deglitched
// (R9) Boost PWM entry at 90 mA, exit 30 mA
// (R10) Buck PFM: peak trip off, restart below regulation
// (R11) Battery undervoltage 100-150 ms drops outputs
// (R12) Fault: discharge outputs, then cool off
// (R13) Restart after 1.3 s cool-off if battery ok
// (R14) Fifteenth fault cycle latches outputs off
// (R15) Power cycle or enable toggle clears latch-off
// (R16) Output out of tolerance past deglitch faults
// (R17) Boost short: linear limit, latch after 30 ms
// (R18) Low-side limit: swap switches until next clock
// (R19) Boost overload 60-120 ms faults both outputs
// (R20) Discharge on while disabled or supply not ok
// (R21) All durations from one millisecond tick
// (R22) Reset and enable rise clear retries, latches
`timescale 1ns/1ns
module drfs_sequencer #(
    parameter int unsigned TICK_CYCLES = drfs_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic enable_pin,
    input wire logic battery_input_low,
    input wire logic battery_input_uv,
    input wire logic boost_output_at_battery,
    input wire logic boost_output_above_1v6,
    input wire logic boost_feedback_sense_ok,
    input wire logic buck_feedback_sense_ok,
    input wire logic boost_zero_current,
    input wire logic buck_zero_current,
    input wire logic boost_load_high,
    input wire logic boost_load_low,
    input wire logic buck_peak_trip,
    input wire logic buck_below_reg,
    input wire logic boost_ls_ilim,
    input wire logic boost_hs_short,
    input wire logic boost_overload,
    input wire logic boost_sw_clock,
    output logic indicator_led,
    output logic supply_ok_flag,
    output logic boost_hs_linear,
    output logic boost_fixed_duty_en,
    output logic boost_pfm_en,
    output logic boost_pwm_mode,
    output logic boost_ls_on,
    output logic boost_hs_on,
    output logic buck_en,
    output logic buck_hs_on,
    output logic boost_ring_sw,
    output logic buck_ring_sw,
    output logic boost_discharge,
    output logic buck_discharge,
    output logic latched_off
);
    typedef struct packed {
        drfs_pkg::drfs_state_t st;
        logic [drfs_pkg::TICK_W-1:0] tick;
        logic [15:0] tmr;
        logic [15:0] uv_cnt;
        logic [15:0] oot_cnt;
        logic [15:0] ovl_cnt;
        logic [15:0] sc_cnt;
        logic [11:0] blink;
        logic [3:0] retry;
        logic en_d;
        logic sw_d;
        logic pwm;
        logic ls_on;
        logic hs_on;
        logic hs_lin;
        logic fixed_en;
        logic pfm_en;
        logic buck_en;
        logic buck_hs;
        logic ring1;
        logic ring2;
        logic pg;
        logic led;
        logic dis1;
        logic dis2;
        logic latched;
    } drfs_regs_t;

    drfs_regs_t r;
    drfs_regs_t n;
    logic [drfs_pkg::IN_W-1:0] s;
    logic tk;
    logic en_rise;
    logic active;
    logic active_n;
    logic pg_cond;
    logic fault;
    logic short_trip;
    logic fault_take;
    logic switching_n;
    logic sw_rise;

    drfs_sync #(
        .W(drfs_pkg::IN_W)
    ) u_sync (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .d({boost_sw_clock, boost_overload, boost_hs_short, boost_ls_ilim,
            buck_below_reg, buck_peak_trip, boost_load_low, boost_load_high,
            buck_zero_current, boost_zero_current, buck_feedback_sense_ok,
            boost_feedback_sense_ok, boost_output_above_1v6,
            boost_output_at_battery, battery_input_uv, battery_input_low,
            enable_pin}),
        .q(s)
    );

    // Qualification timer: zero when idle, else counts ticks, saturating
    function automatic logic [15:0] drfs_run(
        input logic cond,
        input logic t,
        input logic [15:0] c
    );
        logic [15:0] v;
        v = c;
        if (!cond) begin
            v = 16'h0000;
        end else if (t && c != 16'hFFFF) begin
            v = c + 16'h0001;
        end
        return v;
    endfunction

    function automatic logic drfs_is_active(input drfs_pkg::drfs_state_t st);
        return st != drfs_pkg::DRFS_OFF && st != drfs_pkg::DRFS_COOL &&
            st != drfs_pkg::DRFS_LATCH;
    endfunction

    always_comb begin
        n = r;
        tk = (r.tick == drfs_pkg::TICK_W'(TICK_CYCLES - 1)); // R21
        n.tick = tk ? '0 : r.tick + 1'b1;
        en_rise = s[drfs_pkg::IN_EN] && !r.en_d;
        n.en_d = s[drfs_pkg::IN_EN];
        active = drfs_is_active(r.st);

        // Indicator
        if (tk) begin
            n.blink = (r.blink == drfs_pkg::BLINK_TICKS - 12'h001) ?
                12'h000 : r.blink + 12'h001;
        end
        if (s[drfs_pkg::IN_BAT_LOW]) begin
            n.led = (n.blink < drfs_pkg::BLINK_LIT_TICKS); // R1
        end else begin
            n.led = 1'b1; // R2
        end

        // Fault qualification
        pg_cond = s[drfs_pkg::IN_FB1_OK] && s[drfs_pkg::IN_FB2_OK] &&
            !s[drfs_pkg::IN_BAT_UV]; // R8
        n.uv_cnt = drfs_run(active && s[drfs_pkg::IN_BAT_UV], tk,
            r.uv_cnt); // R11
        n.oot_cnt = drfs_run(r.pg && !(s[drfs_pkg::IN_FB1_OK] &&
            s[drfs_pkg::IN_FB2_OK]), tk, r.oot_cnt); // R16
        n.ovl_cnt = drfs_run(active && s[drfs_pkg::IN_OVERLOAD], tk,
            r.ovl_cnt); // R19
        n.sc_cnt = drfs_run(active && s[drfs_pkg::IN_SHORT], tk,
            r.sc_cnt); // R17
        fault = r.uv_cnt >= drfs_pkg::UV_TICKS ||
            r.oot_cnt >= drfs_pkg::OOT_TICKS ||
            r.ovl_cnt >= drfs_pkg::OVL_TICKS;
        short_trip = r.sc_cnt >= drfs_pkg::SHORT_TICKS;
        fault_take = 1'b0;

        if (tk && r.tmr != 16'hFFFF) begin
            n.tmr = r.tmr + 16'h0001;
        end

        case (r.st)
            drfs_pkg::DRFS_OFF: begin
            end
            drfs_pkg::DRFS_LINEAR: begin
                if (s[drfs_pkg::IN_AT_BAT]) begin
                    n.st = drfs_pkg::DRFS_FIXED; // R4
                end
            end
            drfs_pkg::DRFS_FIXED: begin
                if (s[drfs_pkg::IN_ABOVE_1V6]) begin
                    n.st = drfs_pkg::DRFS_RAMP; // R5
                end
            end
            drfs_pkg::DRFS_RAMP: begin
                if (s[drfs_pkg::IN_FB1_OK]) begin
                    n.st = drfs_pkg::DRFS_BUCK; // R6
                end
            end
            drfs_pkg::DRFS_BUCK: begin
                if (s[drfs_pkg::IN_FB2_OK]) begin
                    n.st = drfs_pkg::DRFS_PG_WAIT;
                    n.tmr = 16'h0000;
                end
            end
            drfs_pkg::DRFS_PG_WAIT: begin
                // Delay restarts if the supply condition wavers
                if (!pg_cond) begin
                    n.tmr = 16'h0000;
                end else if (r.tmr >= drfs_pkg::PG_TICKS) begin
                    n.st = drfs_pkg::DRFS_RUN; // R7
                    n.pg = 1'b1;
                end
            end
            drfs_pkg::DRFS_RUN: begin
            end
            drfs_pkg::DRFS_COOL: begin
                if (r.tmr >= drfs_pkg::COOL_TICKS &&
                    !s[drfs_pkg::IN_BAT_UV]) begin
                    n.st = drfs_pkg::DRFS_LINEAR; // R13
                end
            end
            drfs_pkg::DRFS_LATCH: begin
            end
            default: begin
                n.st = drfs_pkg::DRFS_OFF;
            end
        endcase

        if (!s[drfs_pkg::IN_EN]) begin
            n.st = drfs_pkg::DRFS_OFF;
            n.pg = 1'b0;
        end else if (en_rise) begin
            // Enable toggle is also the way out of latch-off
            n.st = drfs_pkg::DRFS_LINEAR; // R15
            n.retry = 4'h0; // R22
            n.pg = 1'b0;
        end else if (active && short_trip) begin
            n.st = drfs_pkg::DRFS_LATCH; // R17
            n.pg = 1'b0;
        end else if (active && fault) begin
            fault_take = 1'b1;
            n.pg = 1'b0; // R11
            n.tmr = 16'h0000;
            n.retry = r.retry + 4'h1; // R14
            n.st = (r.retry == drfs_pkg::RETRY_MAX - 4'h1) ?
                drfs_pkg::DRFS_LATCH : drfs_pkg::DRFS_COOL; // R12
        end
        active_n = drfs_is_active(n.st);

        // Boost power stage
        n.hs_lin = (n.st == drfs_pkg::DRFS_LINEAR) ||
            (active_n && s[drfs_pkg::IN_SHORT]); // R4
        n.fixed_en = (n.st == drfs_pkg::DRFS_FIXED); // R5
        if (!active_n || n.st == drfs_pkg::DRFS_LINEAR) begin
            n.pwm = 1'b0;
        end else if (s[drfs_pkg::IN_LOAD_HI]) begin
            n.pwm = 1'b1; // R9
        end else if (s[drfs_pkg::IN_LOAD_LO]) begin
            n.pwm = 1'b0; // R9
        end
        n.pfm_en = active_n && !n.pwm && n.st != drfs_pkg::DRFS_LINEAR &&
            n.st != drfs_pkg::DRFS_FIXED; // R5
        n.sw_d = s[drfs_pkg::IN_SW_CLK];
        sw_rise = s[drfs_pkg::IN_SW_CLK] && !r.sw_d;
        switching_n = n.fixed_en || n.pwm;
        if (!switching_n) begin
            n.ls_on = 1'b0;
            n.hs_on = 1'b0;
        end else if (s[drfs_pkg::IN_LS_ILIM]) begin
            n.ls_on = 1'b0; // R18
            n.hs_on = 1'b1; // R18
        end else if (sw_rise) begin
            // Only a fresh clock edge may turn the low side back on
            n.ls_on = 1'b1; // R18
            n.hs_on = 1'b0;
        end else if (!s[drfs_pkg::IN_SW_CLK] && r.ls_on) begin
            n.ls_on = 1'b0;
            n.hs_on = 1'b1;
        end
        n.ring1 = active_n && !n.ls_on && !n.hs_on &&
            (s[drfs_pkg::IN_ZI1] || r.ring1); // R3

        // Buck power stage
        n.buck_en = n.st == drfs_pkg::DRFS_BUCK ||
            n.st == drfs_pkg::DRFS_PG_WAIT || n.st == drfs_pkg::DRFS_RUN;
        if (!n.buck_en || s[drfs_pkg::IN_BUCK_PEAK]) begin
            n.buck_hs = 1'b0; // R10
        end else if (s[drfs_pkg::IN_BUCK_LOW]) begin
            n.buck_hs = 1'b1; // R10
        end
        n.ring2 = n.buck_en && !n.buck_hs &&
            (s[drfs_pkg::IN_ZI2] || r.ring2); // R3

        // Discharge follows enable and the supply-ok output
        n.dis1 = !s[drfs_pkg::IN_EN] || !n.pg; // R20
        n.dis2 = !s[drfs_pkg::IN_EN] || !n.pg; // R12
        n.latched = (n.st == drfs_pkg::DRFS_LATCH);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r <= '0; // R22
            r.st <= drfs_pkg::DRFS_OFF;
            r.dis1 <= 1'b1;
            r.dis2 <= 1'b1;
        end else if (ce) begin
            r <= n;
        end
    end

    assign indicator_led = r.led;
    assign supply_ok_flag = r.pg;
    assign boost_hs_linear = r.hs_lin;
    assign boost_fixed_duty_en = r.fixed_en;
    assign boost_pfm_en = r.pfm_en;
    assign boost_pwm_mode = r.pwm;
    assign boost_ls_on = r.ls_on;
    assign boost_hs_on = r.hs_on;
    assign buck_en = r.buck_en;
    assign buck_hs_on = r.buck_hs;
    assign boost_ring_sw = r.ring1;
    assign buck_ring_sw = r.ring2;
    assign boost_discharge = r.dis1;
    assign buck_discharge = r.dis2;
    assign latched_off = r.latched;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn || !ce);

    sequence s_en_edge;
        s[drfs_pkg::IN_EN] && !r.en_d;
    endsequence

    sequence s_last_retry;
        fault_take && r.retry == drfs_pkg::RETRY_MAX - 4'h1;
    endsequence

    a_blink_dark: assert property ( // R1
        s[drfs_pkg::IN_BAT_LOW] && r.blink >= drfs_pkg::BLINK_LIT_TICKS &&
        r.blink != drfs_pkg::BLINK_TICKS - 12'h001 |=> !indicator_led)
        else $error("indicator lit in dark blink phase");
    a_led_steady: assert property ( // R2
        !s[drfs_pkg::IN_BAT_LOW] |=> indicator_led)
        else $error("indicator not steady with good battery");
    a_ring_cause: assert property ( // R3
        $rose(boost_ring_sw) |-> $past(s[drfs_pkg::IN_ZI1]) && !boost_ls_on)
        else $error("boost anti-ring switch closed without zero current");
    a_start_linear: assert property ( // R4
        s_en_edge |=> r.st == drfs_pkg::DRFS_LINEAR && boost_hs_linear)
        else $error("enable rise did not start linear phase");
    a_buck_gate: assert property ( // R6
        $rose(buck_en) |-> $past(s[drfs_pkg::IN_FB1_OK]))
        else $error("buck enabled before boost in tolerance");
    a_pg_delay: assert property ( // R7
        $rose(supply_ok_flag) |-> $past(r.tmr) >= drfs_pkg::PG_TICKS &&
        $past(r.st == drfs_pkg::DRFS_PG_WAIT))
        else $error("supply-ok rose before turn-on delay");
    a_mode_hyst: assert property ( // R9
        !boost_pwm_mode && !s[drfs_pkg::IN_LOAD_HI] |=> !boost_pwm_mode)
        else $error("PWM entered below the entry load");
    a_buck_peak: assert property ( // R10
        s[drfs_pkg::IN_BUCK_PEAK] |=> !buck_hs_on)
        else $error("buck high side on after peak trip");
    a_fault_drop: assert property ( // R11
        fault_take |=> !supply_ok_flag && boost_discharge && !buck_en)
        else $error("fault did not drop outputs");
    a_retry_latch: assert property ( // R14
        s_last_retry |=> latched_off [*2])
        else $error("fifteenth fault did not latch off");
    a_short_latch: assert property ( // R17
        active && short_trip && s[drfs_pkg::IN_EN] && r.en_d |=> latched_off)
        else $error("persistent short did not latch off");
    a_ilim_swap: assert property ( // R18
        s[drfs_pkg::IN_LS_ILIM] |=> !boost_ls_on)
        else $error("low side on after current limit");
    a_discharge_on: assert property ( // R20
        !supply_ok_flag |-> boost_discharge && buck_discharge)
        else $error("discharge off while supply not ok");
endmodule // drfs_sequencer

/* File: drfs_pkg.sv */
package drfs_pkg;
    // Base timing
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned TICK_NS = 1000000;
    localparam int unsigned TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    localparam int unsigned TICK_W = 17;
    localparam int unsigned TICK_MS = 1;
    localparam int unsigned CNT_W = 16;

    // Durations in milliseconds, picked inside the permitted windows
    localparam int unsigned BLINK_PERIOD_MS = 4000;
    localparam int unsigned BLINK_DUTY_PCT = 25;
    localparam int unsigned PG_DELAY_MS = 20;
    localparam int unsigned UV_FILTER_MS = 120;
    localparam int unsigned OOT_DEGLITCH_MS = 80;
    localparam int unsigned OVERLOAD_MS = 80;
    localparam int unsigned SHORT_MS = 30;
    localparam int unsigned COOL_OFF_MS = 1300;

    // Same durations in ticks
    localparam logic [11:0] BLINK_TICKS = 12'(BLINK_PERIOD_MS / TICK_MS);
    localparam logic [11:0] BLINK_LIT_TICKS =
        12'(BLINK_PERIOD_MS * BLINK_DUTY_PCT / 100 / TICK_MS);
    localparam logic [15:0] PG_TICKS = 16'(PG_DELAY_MS / TICK_MS);
    localparam logic [15:0] UV_TICKS = 16'(UV_FILTER_MS / TICK_MS);
    localparam logic [15:0] OOT_TICKS = 16'(OOT_DEGLITCH_MS / TICK_MS);
    localparam logic [15:0] OVL_TICKS = 16'(OVERLOAD_MS / TICK_MS);
    localparam logic [15:0] SHORT_TICKS = 16'(SHORT_MS / TICK_MS);
    localparam logic [15:0] COOL_TICKS = 16'(COOL_OFF_MS / TICK_MS);

    localparam logic [3:0] RETRY_MAX = 4'hF;

    // Bit positions of the synchronised input vector
    localparam int unsigned IN_W = 17;
    localparam int unsigned IN_EN = 0;
    localparam int unsigned IN_BAT_LOW = 1;
    localparam int unsigned IN_BAT_UV = 2;
    localparam int unsigned IN_AT_BAT = 3;
    localparam int unsigned IN_ABOVE_1V6 = 4;
    localparam int unsigned IN_FB1_OK = 5;
    localparam int unsigned IN_FB2_OK = 6;
    localparam int unsigned IN_ZI1 = 7;
    localparam int unsigned IN_ZI2 = 8;
    localparam int unsigned IN_LOAD_HI = 9;
    localparam int unsigned IN_LOAD_LO = 10;
    localparam int unsigned IN_BUCK_PEAK = 11;
    localparam int unsigned IN_BUCK_LOW = 12;
    localparam int unsigned IN_LS_ILIM = 13;
    localparam int unsigned IN_SHORT = 14;
    localparam int unsigned IN_OVERLOAD = 15;
    localparam int unsigned IN_SW_CLK = 16;

    typedef enum logic [3:0] {
        DRFS_OFF,
        DRFS_LINEAR,
        DRFS_FIXED,
        DRFS_RAMP,
        DRFS_BUCK,
        DRFS_PG_WAIT,
        DRFS_RUN,
        DRFS_COOL,
        DRFS_LATCH
    } drfs_state_t;
endpackage

/* File: drfs_sync.sv */
`timescale 1ns/1ns
module drfs_sync #(
    parameter int unsigned W = 1
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } drfs_sync_t;

    drfs_sync_t r;
    drfs_sync_t n;

    // Stage one feeds only stage two; the output moves when two and three agree
    always_comb begin
        n = r;
        n.s1 = d;
        n.s2 = r.s1;
        n.s3 = r.s2;
        n.q = (r.s2 & r.s3) | (r.q & (r.s2 | r.s3));
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
        end else if (ce) begin
            r <= n;
        end
    end

    assign q = r.q;
endmodule // drfs_sync

/* File: drfs_far_side.sv */
`timescale 1ns/1ns
// Analog side: comparators answer only while the drivers feed the rails
module drfs_far_side (
    input wire logic clk,
    input wire logic resetn,
    input wire logic boost_hs_linear,
    input wire logic boost_fixed_duty_en,
    input wire logic boost_pfm_en,
    input wire logic boost_pwm_mode,
    input wire logic buck_en,
    input wire logic stall,
    input wire logic fb2_drop,
    output logic boost_output_at_battery,
    output logic boost_output_above_1v6,
    output logic boost_feedback_sense_ok,
    output logic buck_feedback_sense_ok,
    output logic boost_sw_clock
);
    logic [7:0] ramp_r;
    logic [7:0] buck_ramp_r;
    logic [5:0] sw_div_r;
    logic driven;

    // A stalled or released rail collapses at once, never holds its level
    assign driven = !stall &&
        (boost_hs_linear || boost_fixed_duty_en || boost_pfm_en ||
        boost_pwm_mode);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ramp_r <= 8'h00;
            buck_ramp_r <= 8'h00;
            sw_div_r <= 6'h00;
        end else begin
            sw_div_r <= sw_div_r + 6'h01;
            if (!driven) begin
                ramp_r <= 8'h00;
            end else if (ramp_r != 8'hFF) begin
                ramp_r <= ramp_r + 8'h01;
            end
            if (!buck_en) begin
                buck_ramp_r <= 8'h00;
            end else if (buck_ramp_r != 8'hFF) begin
                buck_ramp_r <= buck_ramp_r + 8'h01;
            end
        end
    end

    assign boost_output_at_battery = ramp_r >= 8'h14;
    assign boost_output_above_1v6 = ramp_r >= 8'h28;
    assign boost_feedback_sense_ok = ramp_r >= 8'h3C;
    assign buck_feedback_sense_ok = (buck_ramp_r >= 8'h14) && !fb2_drop;
    // Slow switching clock so a limit trip fits inside one high phase
    assign boost_sw_clock = sw_div_r[5];
endmodule // drfs_far_side

/* File: dual_rail_fault_sequencer_bench.sv */
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
    begin checks++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("unexpected %s expected %0d seen %0d", nm, ex, got); end end
module dual_rail_fault_sequencer_bench;
    localparam int T = 2;
    localparam int PG = int'(drfs_pkg::PG_TICKS);
    localparam int UV = int'(drfs_pkg::UV_TICKS);
    localparam int OOT = int'(drfs_pkg::OOT_TICKS);
    localparam int OVL = int'(drfs_pkg::OVL_TICKS);
    localparam int SH = int'(drfs_pkg::SHORT_TICKS);
    localparam int COOL = int'(drfs_pkg::COOL_TICKS);
    localparam int BL = int'(drfs_pkg::BLINK_TICKS);
    localparam int LIT = int'(drfs_pkg::BLINK_LIT_TICKS);
    int n_mismatch = 0;
    int checks = 0;
    int cycles = 0;
    logic clk = 1'b0, resetn = 1'b0, enable_pin = 1'b0, stall = 1'b0;
    logic ce = 1'b1;
    logic battery_input_low = 1'b0, battery_input_uv = 1'b0;
    logic boost_zero_current = 1'b0, buck_zero_current = 1'b0;
    logic boost_load_high = 1'b0, boost_load_low = 1'b0;
    logic buck_peak_trip = 1'b0, buck_below_reg = 1'b0, fb2_drop = 1'b0;
    logic boost_ls_ilim = 1'b0, boost_hs_short = 1'b0, boost_overload = 1'b0;
    logic boost_output_at_battery, boost_output_above_1v6, boost_sw_clock;
    logic boost_feedback_sense_ok, buck_feedback_sense_ok;
    logic indicator_led, supply_ok_flag, boost_hs_linear, boost_pwm_mode;
    logic boost_fixed_duty_en, boost_pfm_en, boost_ls_on, boost_hs_on;
    logic buck_en, buck_hs_on, boost_ring_sw, buck_ring_sw, latched_off;
    logic boost_discharge, buck_discharge;

    drfs_sequencer #(.TICK_CYCLES(T)) drfs_sequencer_inst (
        .clk, .resetn, .ce, .enable_pin, .battery_input_low,
        .battery_input_uv, .boost_output_at_battery, .boost_output_above_1v6,
        .boost_feedback_sense_ok, .buck_feedback_sense_ok,
        .boost_zero_current, .buck_zero_current, .boost_load_high,
        .boost_load_low, .buck_peak_trip, .buck_below_reg, .boost_ls_ilim,
        .boost_hs_short, .boost_overload, .boost_sw_clock, .indicator_led,
        .supply_ok_flag, .boost_hs_linear, .boost_fixed_duty_en,
        .boost_pfm_en, .boost_pwm_mode, .boost_ls_on, .boost_hs_on, .buck_en,
        .buck_hs_on, .boost_ring_sw, .buck_ring_sw, .boost_discharge,
        .buck_discharge, .latched_off
    );

    drfs_far_side drfs_far_side_inst (
        .clk, .resetn, .boost_hs_linear, .boost_fixed_duty_en, .boost_pfm_en,
        .boost_pwm_mode, .buck_en, .stall, .fb2_drop, .boost_output_at_battery,
        .boost_output_above_1v6, .boost_feedback_sense_ok,
        .buck_feedback_sense_ok, .boost_sw_clock
    );

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic tally_and_finish();
        if (n_mismatch == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Long fault cycling dominates the run time
    always @(posedge clk) begin
        cycles++;
        if (cycles == 95000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic toggle_enable();
        int k;
        enable_pin = 1'b0;
        step(6);
        `CHK("off discharge", 1'b1, boost_discharge & buck_discharge)
        enable_pin = 1'b1;
        for (k = 0; k < 50 && boost_hs_linear !== 1'b1; k++) step(1);
        `CHK("linear start", 1'b1, boost_hs_linear)
        `CHK("buck early", 1'b0, buck_en)
    endtask

    task automatic do_startup();
        int k;
        toggle_enable();
        for (k = 0; k < 100 && boost_fixed_duty_en !== 1'b1; k++) step(1);
        `CHK("fixed duty", 1'b1, boost_fixed_duty_en & !boost_hs_linear)
        for (k = 0; k < 400 && buck_en !== 1'b1; k++) step(1);
        `CHK("fb1 at buck", 1'b1, boost_feedback_sense_ok)
        `CHK("pfm handover", 1'b1, boost_pfm_en & !boost_hs_linear)
        for (k = 0; k < 200 && supply_ok_flag !== 1'b1; k++) step(1);
        `CHK("pg delay", 1'b1, k >= PG*T + 20 && k <= (PG+2)*T + 30)
        step(2);
        `CHK("run discharge", 1'b0, boost_discharge | buck_discharge)
    endtask

    task automatic t_blink();
        int k, n;
        battery_input_low = 1'b1;
        step(10);
        n = 0;
        for (k = 0; k < BL*T; k++) begin
            n += int'(indicator_led === 1'b1);
            step(1);
        end
        `CHK("lit cycles", LIT*T, n)
        battery_input_low = 1'b0;
        step(8);
        `CHK("led steady", 1'b1, indicator_led)
    endtask

    task automatic t_buck();
        ce = 1'b0;
        enable_pin = 1'b0;
        step(10);
        enable_pin = 1'b1;
        ce = 1'b1;
        step(8);
        `CHK("frozen", 1'b0, buck_discharge | !supply_ok_flag)
        buck_below_reg = 1'b1;
        step(8);
        `CHK("buck on", 1'b1, buck_hs_on)
        buck_below_reg = 1'b0;
        buck_peak_trip = 1'b1;
        step(8);
        `CHK("buck peak off", 1'b0, buck_hs_on)
        buck_peak_trip = 1'b0;
        buck_zero_current = 1'b1;
        boost_zero_current = 1'b1;
        step(8);
        buck_zero_current = 1'b0;
        boost_zero_current = 1'b0;
        step(8);
        `CHK("ring held", 1'b1, buck_ring_sw)
        `CHK("boost ring", 1'b1, boost_ring_sw)
        buck_below_reg = 1'b1;
        step(8);
        `CHK("ring open", 1'b0, buck_ring_sw)
        buck_below_reg = 1'b0;
    endtask

    task automatic t_pwm();
        int k;
        boost_load_high = 1'b1;
        step(8);
        boost_load_high = 1'b0;
        boost_zero_current = 1'b1;
        step(8);
        boost_zero_current = 1'b0;
        `CHK("pwm held", 1'b1, boost_pwm_mode)
        for (k = 0; k < 200 && boost_ls_on !== 1'b1; k++) step(1);
        `CHK("boost ring open", 1'b0, boost_ring_sw)
        boost_ls_ilim = 1'b1;
        step(6);
        `CHK("ilim swap", 1'b1, !boost_ls_on & boost_hs_on)
        boost_ls_ilim = 1'b0;
        step(6);
        `CHK("ls waits", 1'b0, boost_ls_on)
        for (k = 0; k < 100 && boost_ls_on !== 1'b1; k++) step(1);
        `CHK("ls next clock", 1'b1, boost_ls_on)
        boost_load_low = 1'b1;
        step(8);
        boost_load_low = 1'b0;
        `CHK("pfm back", 1'b0, boost_pwm_mode)
    endtask

    task automatic t_uv();
        int k;
        stall = 1'b1;
        toggle_enable();
        battery_input_uv = 1'b1;
        for (k = 0; k < (UV+4)*T+20 && boost_hs_linear === 1'b1; k++) step(1);
        `CHK("uv filter", 1'b1, k >= UV*T && k <= (UV+2)*T + 10)
        step(2);
        `CHK("uv discharge", 1'b1, boost_discharge & buck_discharge)
        `CHK("uv pg", 1'b0, supply_ok_flag | boost_pfm_en)
        stall = 1'b0;
        for (k = 0; k < COOL*T+200 && boost_hs_linear !== 1'b1; k++) begin
            if (k == COOL*T + 100) battery_input_uv = 1'b0;
            step(1);
        end
        `CHK("uv restart", 1'b1, k >= COOL*T+100 && boost_hs_linear)
    endtask

    task automatic t_oot();
        int k;
        do_startup();
        fb2_drop = 1'b1;
        for (k = 0; k < (OOT+4)*T+20 && supply_ok_flag === 1'b1; k++) step(1);
        `CHK("deglitch", 1'b1, k >= OOT*T && k <= (OOT+2)*T + 10)
        fb2_drop = 1'b0;
        for (k = 0; k < (COOL+4)*T+20 && boost_hs_linear !== 1'b1; k++) step(1);
        `CHK("cool off", 1'b1, k >= COOL*T && k <= (COOL+2)*T + 10)
    endtask

    task automatic t_latch();
        int k, j, n;
        logic prev;
        stall = 1'b1;
        boost_overload = 1'b1;
        toggle_enable();
        for (j = 0; j < 400 && boost_hs_linear === 1'b1; j++) step(1);
        `CHK("overload", 1'b1, j >= OVL*T - 6 && j <= (OVL+2)*T + 8)
        n = 1;
        prev = 1'b0;
        for (k = 0; k < 60000 && latched_off !== 1'b1; k++) begin
            if (boost_hs_linear === 1'b1 && prev !== 1'b1) n++;
            prev = boost_hs_linear;
            step(1);
        end
        `CHK("retries", 15, n)
        step(COOL*T + 100);
        `CHK("stays off", 1'b0, boost_hs_linear)
        boost_overload = 1'b0;
        stall = 1'b0;
        do_startup();
        `CHK("latch cleared", 1'b0, latched_off)
    endtask

    task automatic t_short();
        int k;
        do_startup();
        boost_hs_short = 1'b1;
        for (k = 0; k < (SH+4)*T+20 && latched_off !== 1'b1; k++) step(1);
        `CHK("short time", 1'b1, k >= SH*T && k <= (SH+2)*T + 10)
        `CHK("short off", 1'b0, supply_ok_flag | boost_hs_linear)
        boost_hs_short = 1'b0;
        step(400);
        `CHK("no retry", 1'b1, latched_off & !boost_hs_linear)
        do_startup();
        `CHK("short cleared", 1'b0, latched_off)
    endtask

    initial begin
        repeat (4) @(posedge clk);
        #1;
        `CHK("reset discharge", 1'b1, boost_discharge & buck_discharge)
        `CHK("reset pg", 1'b0, supply_ok_flag)
        resetn = 1'b1;
        step(6);
        `CHK("led on", 1'b1, indicator_led)
        do_startup();
        t_blink();
        t_buck();
        t_pwm();
        t_uv();
        t_oot();
        t_latch();
        t_short();
        tally_and_finish();
    end
endmodule // dual_rail_fault_sequencer_bench
